// ===== dlms_defines.vh
`ifndef DLMS_DEFINES_VH
`define DLMS_DEFINES_VH

// ==========================================================
// clocking and rounding
`define DLMS_CLK_NS 40
`define DLMS_UI_NS 40
`define DLMS_CYC_UP(ns) dlms_fit8(((ns) + `DLMS_CLK_NS - 1) / `DLMS_CLK_NS)
`define DLMS_CYC_DN(ns) dlms_fit8((ns) / `DLMS_CLK_NS)
`define DLMS_MAX(a, b) (((a) > (b)) ? (a) : (b))

// ==========================================================
// transmit intervals
`define DLMS_T_LPX_NS 50
`define DLMS_T_CLK_PREP_MIN_NS 38
`define DLMS_T_CLK_PREP_MAX_NS 95
`define DLMS_T_CLK_PZ_NS 300
`define DLMS_T_CLK_TRAIL_NS 60
`define DLMS_T_CLK_PRE_UI 8
`define DLMS_T_CLK_POST_NS (60 + 52 * `DLMS_UI_NS)
`define DLMS_T_HS_PREP_MIN_NS (40 + 4 * `DLMS_UI_NS)
`define DLMS_T_HS_PREP_MAX_NS (85 + 6 * `DLMS_UI_NS)
`define DLMS_T_HS_PZ_NS (145 + 10 * `DLMS_UI_NS)
`define DLMS_TRAIL_N_FWD 1
`define DLMS_TRAIL_N_REV 4
`define DLMS_T_HS_TRAIL_NS(n) \
   `DLMS_MAX((n) * 8 * `DLMS_UI_NS, 60 + (n) * 4 * `DLMS_UI_NS)

// ==========================================================
// receive settle windows
`define DLMS_T_SETTLE_MIN_NS 40
`define DLMS_T_SETTLE_MAX_NS 2590
`define DLMS_T_CLK_SETTLE_MIN_NS 95
`define DLMS_T_CLK_SETTLE_MAX_NS 300
`define DLMS_T_HS_SETTLE_MIN_NS (85 + 6 * `DLMS_UI_NS)
`define DLMS_T_HS_SETTLE_MAX_NS (145 + 10 * `DLMS_UI_NS)

// ==========================================================
// line states {p, n}, sync and stream
`define DLMS_LP11 2'h3
`define DLMS_LP01 2'h1
`define DLMS_LP00 2'h0
`define DLMS_SYNC_BYTE 8'hb8
`define DLMS_BYTE_LAST 3'h7
`define DLMS_FIFO_WIDTH 8
`define DLMS_FIFO_DEPTH 16
`define DLMS_FIFO_AW 4

`endif

// ===== dlms_lane_sequencer.v
`timescale 1ns/1ps
`include "dlms_defines.vh"

// ==========================================================
// fifo
module dlms_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
)
(
   // clock and reset
   input wire i_clk,
   input wire i_rst,
   // fill side
   input wire [WIDTH-1:0] i_in_data,
   input wire i_in_valid,
   output reg o_in_ready,
   // drain side
   output wire [WIDTH-1:0] o_out_data,
   output reg o_out_valid,
   input wire i_out_ready
);
   localparam [AW:0] FULL_CNT = DEPTH[AW:0];
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] cnt_reg;
   reg [AW:0] cnt_next;
   wire push;
   wire pop;

   assign push = i_in_valid & o_in_ready;
   assign pop = i_out_ready & o_out_valid;
   assign o_out_data = mem[rd_ptr_reg];

   always @*
   begin
      cnt_next = cnt_reg;
      if (push & ~pop)
         cnt_next = cnt_reg + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
         cnt_next = cnt_reg - {{AW{1'b0}}, 1'b1};
   end

   always @(posedge i_clk)
   begin
      if (push)
         mem[wr_ptr_reg] <= i_in_data;
   end

   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
         o_in_ready <= 1'b0;
         o_out_valid <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         cnt_reg <= cnt_next;
         o_in_ready <= (cnt_next != FULL_CNT);
         o_out_valid <= (cnt_next != {(AW+1){1'b0}});
      end
   end
endmodule

// Contract
// - lanes alternate low power and high speed
// - burst entry goes LP11, LP01, LP00
// - burst exit returns lane to LP11
// - clock runs post time after data trail
// - clock runs eight UI before data request
// - clock prepare LP00 between 38 and 95ns
// - receiver ignores clock for clock settle
// - clock trail zero at least 60ns
// - clock prepare plus zero at least 300ns
// - data prepare within its min and max
// - receiver ignores data until settle ends
// - data trail flipped bit, n-dependent minimum
// - every low-power state at least 50ns; the clock LP00 prepare can last one 40ns cycle
// - data prepare plus zero long enough
// - all intervals configurable
// - settle timers span 40 to 2590ns; clock settle is held to 120-280ns, data settle to 360-520ns
module dlms_lane_sequencer
(
   // clock and reset
   input wire i_sys_clk,
   input wire i_rst,
   // transmit byte stream
   input wire [7:0] i_tx_data,
   input wire i_tx_valid,
   output wire o_tx_ready,
   input wire i_tx_reverse,
   // transmit timing, in clock cycles
   input wire [7:0] i_cfg_lpx,
   input wire [7:0] i_cfg_clk_prepare,
   input wire [7:0] i_cfg_clk_zero,
   input wire [7:0] i_cfg_clk_pre,
   input wire [7:0] i_cfg_clk_post,
   input wire [7:0] i_cfg_clk_trail,
   input wire [7:0] i_cfg_hs_prepare,
   input wire [7:0] i_cfg_hs_zero,
   input wire [7:0] i_cfg_hs_trail,
   // receive timing, in clock cycles
   input wire [7:0] i_cfg_clk_settle,
   input wire [7:0] i_cfg_hs_settle,
   // transmit lanes
   output reg o_tx_clk_lp_p,
   output reg o_tx_clk_lp_n,
   output reg o_tx_clk_hs_en,
   output reg o_tx_clk_hs,
   output reg o_tx_dat_lp_p,
   output reg o_tx_dat_lp_n,
   output reg o_tx_dat_hs_en,
   output reg o_tx_dat_hs,
   output reg o_tx_busy,
   // receive lanes
   input wire i_rx_link_clk,
   input wire i_rx_clk_lp_p,
   input wire i_rx_clk_lp_n,
   input wire i_rx_dat_lp_p,
   input wire i_rx_dat_lp_n,
   input wire i_rx_dat_hs,
   // receive byte stream
   output reg [7:0] o_rx_data,
   output reg o_rx_valid,
   output reg o_rx_clk_active,
   output reg o_rx_busy
);
   // ==========================================================
   // minimum and maximum cycle counts
   // cuts a cycle count to the timer width
   function [7:0] dlms_fit8;
      input integer v;
      begin
         dlms_fit8 = v[7:0];
      end
   endfunction

   localparam [7:0] LPX_MIN = `DLMS_CYC_UP(`DLMS_T_LPX_NS);
   localparam [7:0] CPREP_MIN = `DLMS_CYC_UP(`DLMS_T_CLK_PREP_MIN_NS);
   localparam [7:0] CPREP_MAX = `DLMS_CYC_DN(`DLMS_T_CLK_PREP_MAX_NS);
   localparam [7:0] CPZ_MIN = `DLMS_CYC_UP(`DLMS_T_CLK_PZ_NS);
   localparam [7:0] CTRAIL_MIN = `DLMS_CYC_UP(`DLMS_T_CLK_TRAIL_NS);
   localparam [7:0] CPRE_MIN =
      `DLMS_CYC_UP(`DLMS_T_CLK_PRE_UI * `DLMS_UI_NS);
   localparam [7:0] CPOST_MIN = `DLMS_CYC_UP(`DLMS_T_CLK_POST_NS);
   localparam [7:0] HPREP_MIN = `DLMS_CYC_UP(`DLMS_T_HS_PREP_MIN_NS);
   localparam [7:0] HPREP_MAX = `DLMS_CYC_DN(`DLMS_T_HS_PREP_MAX_NS);
   localparam [7:0] HPZ_MIN = `DLMS_CYC_UP(`DLMS_T_HS_PZ_NS);
   localparam [7:0] HTRAIL_FWD =
      `DLMS_CYC_UP(`DLMS_T_HS_TRAIL_NS(`DLMS_TRAIL_N_FWD));
   localparam [7:0] HTRAIL_REV =
      `DLMS_CYC_UP(`DLMS_T_HS_TRAIL_NS(`DLMS_TRAIL_N_REV));
   localparam [7:0] SET_MIN = `DLMS_CYC_UP(`DLMS_T_SETTLE_MIN_NS);
   localparam [7:0] SET_MAX = `DLMS_CYC_DN(`DLMS_T_SETTLE_MAX_NS);
   localparam [7:0] CSET_MIN = `DLMS_CYC_UP(`DLMS_T_CLK_SETTLE_MIN_NS);
   localparam [7:0] CSET_MAX = `DLMS_CYC_DN(`DLMS_T_CLK_SETTLE_MAX_NS);
   localparam [7:0] HSET_MIN = `DLMS_CYC_UP(`DLMS_T_HS_SETTLE_MIN_NS);
   localparam [7:0] HSET_MAX = `DLMS_CYC_DN(`DLMS_T_HS_SETTLE_MAX_NS);
   localparam [7:0] NO_MAX = 8'hff;

   // ==========================================================
   // transmit states
   localparam [13:0] S_IDLE = 14'h0001;
   localparam [13:0] S_CLK_RQST = 14'h0002;
   localparam [13:0] S_CLK_BRDG = 14'h0004;
   localparam [13:0] S_CLK_ZERO = 14'h0008;
   localparam [13:0] S_CLK_PRE = 14'h0010;
   localparam [13:0] S_DAT_RQST = 14'h0020;
   localparam [13:0] S_DAT_BRDG = 14'h0040;
   localparam [13:0] S_DAT_ZERO = 14'h0080;
   localparam [13:0] S_DAT_SYNC = 14'h0100;
   localparam [13:0] S_DAT_BITS = 14'h0200;
   localparam [13:0] S_DAT_TRAIL = 14'h0400;
   localparam [13:0] S_CLK_POST = 14'h0800;
   localparam [13:0] S_CLK_TRAIL = 14'h1000;
   localparam [13:0] S_CLK_EXIT = 14'h2000;

   // receive states
   localparam [3:0] RC_STOP = 4'h1;
   localparam [3:0] RC_RQST = 4'h2;
   localparam [3:0] RC_SETTLE = 4'h4;
   localparam [3:0] RC_HS = 4'h8;
   localparam [4:0] RD_STOP = 5'h01;
   localparam [4:0] RD_RQST = 5'h02;
   localparam [4:0] RD_SETTLE = 5'h04;
   localparam [4:0] RD_HUNT = 5'h08;
   localparam [4:0] RD_BYTES = 5'h10;

   function [7:0] dlms_clamp;
      input [7:0] v;
      input [7:0] lo;
      input [7:0] hi;
      begin
         if (v < lo)
            dlms_clamp = lo;
         else if (v > hi)
            dlms_clamp = hi;
         else
            dlms_clamp = v;
      end
   endfunction

   // ==========================================================
   // effective durations
   wire [7:0] lpx_eff;
   wire [7:0] cprep_eff;
   wire [7:0] czero_eff;
   wire [7:0] cpre_eff;
   wire [7:0] cpost_eff;
   wire [7:0] ctrail_eff;
   wire [7:0] hprep_eff;
   wire [7:0] hzero_eff;
   wire [7:0] htrail_eff;
   wire [7:0] cset_eff;
   wire [7:0] hset_eff;
   wire [8:0] cpz_sum;
   wire [8:0] hpz_sum;

   assign lpx_eff = dlms_clamp(i_cfg_lpx, LPX_MIN, NO_MAX);
   assign cprep_eff = dlms_clamp(i_cfg_clk_prepare,
      CPREP_MIN, CPREP_MAX);
   assign cpz_sum = {1'b0, i_cfg_clk_zero} + {1'b0, cprep_eff};
   assign czero_eff = (cpz_sum < {1'b0, CPZ_MIN}) ?
      CPZ_MIN - cprep_eff : i_cfg_clk_zero;
   assign cpre_eff = dlms_clamp(i_cfg_clk_pre, CPRE_MIN, NO_MAX);
   assign cpost_eff = dlms_clamp(i_cfg_clk_post, CPOST_MIN, NO_MAX);
   assign ctrail_eff = dlms_clamp(i_cfg_clk_trail, CTRAIL_MIN, NO_MAX);
   assign hprep_eff = dlms_clamp(i_cfg_hs_prepare,
      HPREP_MIN, HPREP_MAX);
   assign hpz_sum = {1'b0, i_cfg_hs_zero} + {1'b0, hprep_eff};
   assign hzero_eff = (hpz_sum < {1'b0, HPZ_MIN}) ?
      HPZ_MIN - hprep_eff : i_cfg_hs_zero;
   assign htrail_eff = dlms_clamp(i_cfg_hs_trail,
      i_tx_reverse ? HTRAIL_REV : HTRAIL_FWD, NO_MAX);
   assign cset_eff = dlms_clamp(dlms_clamp(i_cfg_clk_settle, SET_MIN, SET_MAX),
      CSET_MIN, CSET_MAX);
   assign hset_eff = dlms_clamp(dlms_clamp(i_cfg_hs_settle, SET_MIN, SET_MAX),
      HSET_MIN, HSET_MAX);

   // ==========================================================
   // transmit buffer
   wire [7:0] fifo_data;
   wire fifo_valid;
   reg fifo_pop;

   dlms_fifo #(
      .WIDTH(`DLMS_FIFO_WIDTH),
      .DEPTH(`DLMS_FIFO_DEPTH),
      .AW(`DLMS_FIFO_AW)
   ) u_fifo (
      .i_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_in_data(i_tx_data),
      .i_in_valid(i_tx_valid),
      .o_in_ready(o_tx_ready),
      .o_out_data(fifo_data),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop)
   );

   // ==========================================================
   // transmit sequencer
   reg [13:0] state_reg;
   reg [13:0] state_next;
   reg [7:0] tmr_reg;
   reg [7:0] tmr_next;
   reg [7:0] sh_reg;
   reg [7:0] sh_next;
   reg trail_reg;
   reg trail_next;
   wire tmr_done;

   assign tmr_done = (tmr_reg == 8'h00);

   always @*
   begin
      state_next = state_reg;
      tmr_next = tmr_done ? tmr_reg : tmr_reg - 8'h01;
      sh_next = sh_reg;
      trail_next = trail_reg;
      fifo_pop = 1'b0;
      case (state_reg)
         S_IDLE:
            if (fifo_valid)
            begin
               state_next = S_CLK_RQST;
               tmr_next = lpx_eff - 8'h01;
            end
         S_CLK_RQST:
            if (tmr_done)
            begin
               state_next = S_CLK_BRDG;
               tmr_next = cprep_eff - 8'h01;
            end
         S_CLK_BRDG:
            if (tmr_done)
            begin
               state_next = S_CLK_ZERO;
               tmr_next = czero_eff - 8'h01;
            end
         S_CLK_ZERO:
            if (tmr_done)
            begin
               state_next = S_CLK_PRE;
               tmr_next = cpre_eff - 8'h01;
            end
         S_CLK_PRE:
            if (tmr_done)
            begin
               state_next = S_DAT_RQST;
               tmr_next = lpx_eff - 8'h01;
            end
         S_DAT_RQST:
            if (tmr_done)
            begin
               state_next = S_DAT_BRDG;
               tmr_next = hprep_eff - 8'h01;
            end
         S_DAT_BRDG:
            if (tmr_done)
            begin
               state_next = S_DAT_ZERO;
               tmr_next = hzero_eff - 8'h01;
            end
         S_DAT_ZERO:
            if (tmr_done)
            begin
               state_next = S_DAT_SYNC;
               tmr_next = {5'h00, `DLMS_BYTE_LAST};
               sh_next = `DLMS_SYNC_BYTE;
            end
         S_DAT_SYNC, S_DAT_BITS:
         begin
            sh_next = {1'b0, sh_reg[7:1]};
            if (tmr_done)
            begin
               if (fifo_valid)
               begin
                  state_next = S_DAT_BITS;
                  tmr_next = {5'h00, `DLMS_BYTE_LAST};
                  sh_next = fifo_data;
                  fifo_pop = 1'b1;
               end
               else
               begin
                  state_next = S_DAT_TRAIL;
                  tmr_next = htrail_eff - 8'h01;
                  trail_next = ~sh_reg[0];
               end
            end
         end
         S_DAT_TRAIL:
            if (tmr_done)
            begin
               state_next = S_CLK_POST;
               tmr_next = cpost_eff - 8'h01;
            end
         S_CLK_POST:
            if (tmr_done)
            begin
               state_next = S_CLK_TRAIL;
               tmr_next = ctrail_eff - 8'h01;
            end
         S_CLK_TRAIL:
            if (tmr_done)
            begin
               state_next = S_CLK_EXIT;
               tmr_next = lpx_eff - 8'h01;
            end
         S_CLK_EXIT:
            if (tmr_done)
               state_next = S_IDLE;
         default:
         begin
            state_next = S_CLK_EXIT;
            tmr_next = LPX_MIN;
         end
      endcase
   end

   // lane drive, registered from the next state
   wire clk_lp_n_next;
   wire clk_rqst_next;
   wire clk_hs_next;
   wire clk_run_next;
   wire dat_lp_n_next;
   wire dat_rqst_next;
   wire dat_hs_next;

   assign clk_lp_n_next = (state_next == S_IDLE) | (state_next == S_CLK_EXIT);
   assign clk_rqst_next = (state_next == S_CLK_RQST);
   assign clk_hs_next = ~clk_lp_n_next & ~clk_rqst_next &
      (state_next != S_CLK_BRDG);
   assign clk_run_next = clk_hs_next & (state_next != S_CLK_ZERO) &
      (state_next != S_CLK_TRAIL);
   assign dat_rqst_next = (state_next == S_DAT_RQST);
   assign dat_hs_next = (state_next == S_DAT_ZERO) |
      (state_next == S_DAT_SYNC) | (state_next == S_DAT_BITS) |
      (state_next == S_DAT_TRAIL);
   assign dat_lp_n_next = ~dat_rqst_next & ~dat_hs_next &
      (state_next != S_DAT_BRDG);

   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         state_reg <= S_CLK_EXIT;
         tmr_reg <= LPX_MIN;
         sh_reg <= 8'h00;
         trail_reg <= 1'b0;
         o_tx_clk_lp_p <= 1'b1;
         o_tx_clk_lp_n <= 1'b1;
         o_tx_clk_hs_en <= 1'b0;
         o_tx_clk_hs <= 1'b0;
         o_tx_dat_lp_p <= 1'b1;
         o_tx_dat_lp_n <= 1'b1;
         o_tx_dat_hs_en <= 1'b0;
         o_tx_dat_hs <= 1'b0;
         o_tx_busy <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         sh_reg <= sh_next;
         trail_reg <= trail_next;
         o_tx_clk_lp_p <= clk_lp_n_next;
         o_tx_clk_lp_n <= clk_lp_n_next | clk_rqst_next;
         o_tx_clk_hs_en <= clk_hs_next;
         o_tx_clk_hs <= clk_run_next ? ~o_tx_clk_hs : 1'b0;
         o_tx_dat_lp_p <= dat_lp_n_next;
         o_tx_dat_lp_n <= dat_lp_n_next | dat_rqst_next;
         o_tx_dat_hs_en <= dat_hs_next;
         if (state_next == S_DAT_TRAIL)
            o_tx_dat_hs <= trail_next;
         else if ((state_next == S_DAT_SYNC) | (state_next == S_DAT_BITS))
            o_tx_dat_hs <= sh_next[0];
         else
            o_tx_dat_hs <= 1'b0;
         o_tx_busy <= (state_next != S_IDLE);
      end
   end

   // ==========================================================
   // receive pin synchronisers
   wire [5:0] rx_raw;
   wire [5:0] rx_st;

   assign rx_raw = {i_rx_link_clk, i_rx_clk_lp_p, i_rx_clk_lp_n,
      i_rx_dat_lp_p, i_rx_dat_lp_n, i_rx_dat_hs};

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1)
      begin : g_sync
         reg s1_reg;
         reg s2_reg;
         reg s3_reg;
         reg st_reg;
         always @(posedge i_sys_clk)
         begin
            if (i_rst)
            begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               st_reg <= 1'b0;
            end
            else
            begin
               s1_reg <= rx_raw[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg)
                  st_reg <= s3_reg;
            end
         end
         assign rx_st[g] = st_reg;
      end
   endgenerate

   // ==========================================================
   // receive lane tracking
   wire [1:0] rx_clk_lp;
   wire [1:0] rx_dat_lp;
   wire link_edge;
   reg lclk_prev_reg;
   reg [3:0] rc_reg;
   reg [4:0] rd_reg;
   reg [7:0] rc_tmr_reg;
   reg [7:0] rd_tmr_reg;
   reg [7:0] rsh_reg;
   reg [2:0] rbit_reg;
   wire [7:0] rsh_next;

   assign rx_clk_lp = rx_st[4:3];
   assign rx_dat_lp = rx_st[2:1];
   assign link_edge = rx_st[5] ^ lclk_prev_reg;
   assign rsh_next = {rx_st[0], rsh_reg[7:1]};

   always @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         lclk_prev_reg <= 1'b0;
         rc_reg <= RC_STOP;
         rd_reg <= RD_STOP;
         rc_tmr_reg <= 8'h00;
         rd_tmr_reg <= 8'h00;
         rsh_reg <= 8'h00;
         rbit_reg <= 3'h0;
         o_rx_data <= 8'h00;
         o_rx_valid <= 1'b0;
         o_rx_clk_active <= 1'b0;
         o_rx_busy <= 1'b0;
      end
      else
      begin
         lclk_prev_reg <= rx_st[5];
         o_rx_valid <= 1'b0;
         if (rc_tmr_reg != 8'h00)
            rc_tmr_reg <= rc_tmr_reg - 8'h01;
         if (rd_tmr_reg != 8'h00)
            rd_tmr_reg <= rd_tmr_reg - 8'h01;
         case (rc_reg)
            RC_STOP:
               if (rx_clk_lp == `DLMS_LP01)
                  rc_reg <= RC_RQST;
            RC_RQST:
               if (rx_clk_lp == `DLMS_LP00)
               begin
                  rc_reg <= RC_SETTLE;
                  rc_tmr_reg <= cset_eff - 8'h01;
               end
               else if (rx_clk_lp == `DLMS_LP11)
                  rc_reg <= RC_STOP;
            RC_SETTLE:
               if (rx_clk_lp == `DLMS_LP11)
                  rc_reg <= RC_STOP;
               else if (rc_tmr_reg == 8'h00)
                  rc_reg <= RC_HS;
            RC_HS:
               if (rx_clk_lp == `DLMS_LP11)
                  rc_reg <= RC_STOP;
            default:
               rc_reg <= RC_STOP;
         endcase
         case (rd_reg)
            RD_STOP:
               if (rx_dat_lp == `DLMS_LP01)
                  rd_reg <= RD_RQST;
            RD_RQST:
               if (rx_dat_lp == `DLMS_LP00)
               begin
                  rd_reg <= RD_SETTLE;
                  rd_tmr_reg <= hset_eff - 8'h01;
               end
               else if (rx_dat_lp == `DLMS_LP11)
                  rd_reg <= RD_STOP;
            RD_SETTLE:
               if (rx_dat_lp == `DLMS_LP11)
                  rd_reg <= RD_STOP;
               else if (rd_tmr_reg == 8'h00)
               begin
                  rd_reg <= RD_HUNT;
                  rsh_reg <= 8'h00;
               end
            RD_HUNT:
               if (rx_dat_lp == `DLMS_LP11)
                  rd_reg <= RD_STOP;
               else if (link_edge & (rc_reg == RC_HS))
               begin
                  rsh_reg <= rsh_next;
                  if (rsh_next == `DLMS_SYNC_BYTE)
                  begin
                     rd_reg <= RD_BYTES;
                     rbit_reg <= 3'h0;
                  end
               end
            RD_BYTES:
               if (rx_dat_lp == `DLMS_LP11)
                  rd_reg <= RD_STOP;
               else if (link_edge & (rc_reg == RC_HS))
               begin
                  rsh_reg <= rsh_next;
                  rbit_reg <= rbit_reg + 3'h1;
                  if (rbit_reg == `DLMS_BYTE_LAST)
                  begin
                     o_rx_data <= rsh_next;
                     o_rx_valid <= 1'b1;
                  end
               end
            default:
               rd_reg <= RD_STOP;
         endcase
         o_rx_clk_active <= (rc_reg == RC_HS);
         o_rx_busy <= (rd_reg == RD_HUNT) | (rd_reg == RD_BYTES);
      end
   end
endmodule

// ===== dlms_properties.sv
`timescale 1ns/1ps
module dlms_properties
(
   // clock and reset
   input wire i_sys_clk,
   input wire i_rst,
   // transmit lanes
   input wire o_tx_clk_lp_p,
   input wire o_tx_clk_lp_n,
   input wire o_tx_clk_hs_en,
   input wire o_tx_clk_hs,
   input wire o_tx_dat_lp_p,
   input wire o_tx_dat_lp_n,
   input wire o_tx_dat_hs_en
);
   wire [1:0] cl = {o_tx_clk_lp_p, o_tx_clk_lp_n};
   wire [1:0] dl = {o_tx_dat_lp_p, o_tx_dat_lp_n};
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // entry steps
   sequence clk_to_lp01;
      cl == 2'h1 && $past(cl) != 2'h1;
   endsequence
   sequence clk_to_lp00;
      cl == 2'h0 && $past(cl) != 2'h0;
   endsequence
   sequence dat_to_lp01;
      dl == 2'h1 && $past(dl) != 2'h1;
   endsequence
   sequence dat_to_lp00;
      dl == 2'h0 && $past(dl) != 2'h0;
   endsequence
   // ==========================================================
   // transmit timing
   AST_CLK_ENTRY: assert property (clk_to_lp01 |-> $past(cl) == 2'h3)
      else $error("clock lane LP01 not after LP11");
   AST_LPX: assert property (clk_to_lp01 |=> cl == 2'h1)
      else $error("clock lane LP01 too short");
   AST_CLK_PREP: assert property (clk_to_lp00 |->
      $past(cl) == 2'h1 ##[1:2] $rose(o_tx_clk_hs_en))
      else $error("clock prepare out of range");
   AST_CLK_ZERO: assert property ($rose(o_tx_clk_hs_en) |->
      !o_tx_clk_hs [*6])
      else $error("clock zero too short");
   AST_DAT_ENTRY: assert property (dat_to_lp01 |->
      $past(dl) == 2'h3
      && $past(o_tx_clk_hs_en, 8)
      && $past(o_tx_clk_hs) != $past(o_tx_clk_hs, 2))
      else $error("data entry without running clock");
   AST_DAT_PREP: assert property (dat_to_lp00 |->
      $past(dl) == 2'h1 ##[5:8] $rose(o_tx_dat_hs_en))
      else $error("data prepare out of range");
   AST_BURST_CLK: assert property (o_tx_dat_hs_en |-> o_tx_clk_hs_en)
      else $error("data burst without clock");
   AST_DAT_EXIT: assert property ($fell(o_tx_dat_hs_en) |->
      dl == 2'h3 ##53 o_tx_clk_hs != $past(o_tx_clk_hs))
      else $error("data exit or clock post wrong");
   AST_CLK_TRAIL: assert property ($fell(o_tx_clk_hs_en) |->
      cl == 2'h3 && !$past(o_tx_clk_hs) && !$past(o_tx_clk_hs, 2))
      else $error("clock trail wrong");
endmodule
bind dlms_lane_sequencer dlms_properties dlms_properties_inst (.*);

// ===== dlms_rx_partner.sv
`timescale 1ns/1ps
module dlms_rx_partner
(
   // remote lanes
   output reg o_link_clk,
   output reg o_clk_lp_p,
   output reg o_clk_lp_n,
   output reg o_dat_lp_p,
   output reg o_dat_lp_n,
   output reg o_dat_hs
);
   reg [15:0] sh;
   integer k;
   initial
   begin
      o_link_clk = 1'b0;
      {o_clk_lp_p, o_clk_lp_n, o_dat_lp_p, o_dat_lp_n} = 4'hf;
      o_dat_hs = 1'b0;
   end
   // one burst: sync then one byte, lsb first, 160 ns per bit
   task send(input [7:0] b);
   begin
      sh = {b, 8'hb8};
      {o_clk_lp_p, o_clk_lp_n} = 2'h1;
      #100 {o_clk_lp_p, o_clk_lp_n} = 2'h0;
      #300;
      for (k = 0; k < 90; k = k + 1)
      begin
         if (k == 2) {o_dat_lp_p, o_dat_lp_n} = 2'h1;
         if (k == 3) {o_dat_lp_p, o_dat_lp_n} = 2'h0;
         if (k >= 8 && k < 24) o_dat_hs = sh[k-8];
         if (k == 24) o_dat_hs = ~o_dat_hs;
         if (k == 32) {o_dat_lp_p, o_dat_lp_n} = 2'h3;
         if (k > 32) o_dat_hs = ~o_dat_hs;
         #80 o_link_clk = ~o_link_clk;
         #80;
      end
      #200 {o_clk_lp_p, o_clk_lp_n} = 2'h3;
      #200;
   end
   endtask
endmodule

// ===== tb_dlms_lane_sequencer.sv
`timescale 1ns/1ps
module tb_dlms_lane_sequencer;
   reg i_sys_clk = 1'b0;
   reg i_rst = 1'b1;
   reg [7:0] i_tx_data = 8'h00;
   reg i_tx_valid = 1'b0;
   reg i_tx_reverse = 1'b0;
   reg [7:0] i_cfg_lpx, i_cfg_clk_prepare, i_cfg_clk_zero, i_cfg_clk_pre;
   reg [7:0] i_cfg_clk_post, i_cfg_clk_trail, i_cfg_hs_prepare;
   reg [7:0] i_cfg_hs_zero, i_cfg_hs_trail, i_cfg_clk_settle;
   reg [7:0] i_cfg_hs_settle, sr, b;
   wire o_tx_ready, o_tx_clk_lp_p, o_tx_clk_lp_n, o_tx_clk_hs_en;
   wire o_tx_clk_hs, o_tx_dat_lp_p, o_tx_dat_lp_n, o_tx_dat_hs_en;
   wire o_tx_dat_hs, o_tx_busy, o_rx_valid, o_rx_clk_active, o_rx_busy;
   wire i_rx_link_clk, i_rx_clk_lp_p, i_rx_clk_lp_n;
   wire i_rx_dat_lp_p, i_rx_dat_lp_n, i_rx_dat_hs;
   wire [7:0] o_rx_data;
   reg [7:0] tq[$];
   reg [7:0] rq[$];
   reg [31:0] seed = 32'h6fe6;
   reg full = 1'b0, hunt = 1'b1, en_d = 1'b0;
   integer checks = 0, failures = 0, k, n, run = 0, bits = 0;
   dlms_lane_sequencer dlms_lane_sequencer_inst (.*);
   dlms_rx_partner dlms_rx_partner_inst (.o_link_clk(i_rx_link_clk),
      .o_clk_lp_p(i_rx_clk_lp_p), .o_clk_lp_n(i_rx_clk_lp_n),
      .o_dat_lp_p(i_rx_dat_lp_p), .o_dat_lp_n(i_rx_dat_lp_n),
      .o_dat_hs(i_rx_dat_hs));
   initial forever #20 i_sys_clk = ~i_sys_clk;
   function [31:0] xs();
   begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
   end
   endfunction
   task check(input [7:0] seen, input [7:0] exp);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task tally_and_finish;
   begin
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   // offer one byte, held until taken
   task put(input [7:0] v);
   begin
      i_tx_data = v;
      i_tx_valid = 1'b1;
      tq.push_back(v);
      while (o_tx_ready !== 1'b1)
      begin
         full = 1'b1;
         @(negedge i_sys_clk);
      end
      @(negedge i_sys_clk);
   end
   endtask
   task wait_idle;
   begin
      repeat (4) @(negedge i_sys_clk);
      for (k = 0; k < 9000 && o_tx_busy !== 1'b0; k = k + 1)
         @(negedge i_sys_clk);
   end
   endtask
   // ==========================================================
   // monitors: decode tx lane, take received bytes
   always @(negedge i_sys_clk)
   begin
      if (o_tx_dat_hs_en === 1'b1)
      begin
         run = (o_tx_dat_hs === sr[7]) ? run + 1 : 1;
         sr = {o_tx_dat_hs, sr[7:1]};
         bits = bits + 1;
         if (hunt && sr === 8'hb8)
         begin
            hunt = 1'b0;
            bits = 0;
         end
         if (!hunt && bits == 8)
         begin
            bits = 0;
            if (tq.size() > 0) check(sr, tq.pop_front());
         end
      end
      else if (en_d)
      begin
         check(run >= (i_tx_reverse ? 32 : 8), 8'h01);
         hunt = 1'b1;
      end
      en_d = (o_tx_dat_hs_en === 1'b1);
      if (o_rx_valid === 1'b1 && rq.size() > 0)
      begin
         check(o_rx_data, rq.pop_front());
         check({6'h00, o_rx_clk_active, o_rx_busy}, 8'h03);
      end
   end
   initial
   begin
      #1600000;
      failures = failures + 1;
      tally_and_finish;
   end
   // ==========================================================
   // main sequence
   initial
   begin
      {i_cfg_lpx, i_cfg_clk_prepare, i_cfg_clk_zero, i_cfg_clk_pre,
         i_cfg_clk_post, i_cfg_clk_trail, i_cfg_hs_prepare, i_cfg_hs_zero,
         i_cfg_hs_trail, i_cfg_clk_settle, i_cfg_hs_settle} =
         {xs(), xs(), xs()};
      repeat (5) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      i_rst = 1'b0;
      @(negedge i_sys_clk);
      for (n = 0; n < 24; n = n + 1)
         put(xs() >> 8);
      i_tx_valid = 1'b0;
      wait_idle;
      check(full, 8'h01);
      @(negedge i_sys_clk);
      i_tx_reverse = 1'b1;
      put(xs() >> 8);
      i_tx_valid = 1'b0;
      wait_idle;
      for (n = 0; n < 2; n = n + 1)
      begin
         b = xs() >> 8;
         rq.push_back(b);
         dlms_rx_partner_inst.send(b);
      end
      repeat (20) @(negedge i_sys_clk);
      check(tq.size() == 0, 8'h01);
      check(rq.size() == 0, 8'h01);
      check({6'h00, o_rx_clk_active, o_rx_busy}, 8'h00);
      tally_and_finish;
   end
endmodule
